// ---- src/eprom_burn_sequencer_decode.sv ----
// eprom_burn_sequencer_decode.sv: burn, blank check, verify and copy-in sequencer
// assumes single-cycle RAM reads/writes and socket reads, and a socket burn
// pulse that the outside times and acknowledges with burnDone
//
// Behaviour
// - burn_key copies the type's RAM region into the socket window from 6000.
// - standard burn blank-checks first; any unerased byte fails at once.
// - after burning each byte is compared with RAM up to the first mismatch; pass or fail shown.
// - a full 2k single-supply standard run lasts about 100 seconds before verification.
// - reset powers the socket down; burn_key powers it up again.
// - copy_in_key reads the target into RAM from 3000, then verifies it.
// - block burn writes a chosen source area to any target start address.
// - block burn performs no blank check.
// - block burn verifies only the transferred block, pass or fail.
// - cursor stepping wraps inside its 4k field; only loads leave it.
// - the high address nibble is latched from the data bus and exported.
// - only the lower 32k is decoded; the upper half is left free.
// - roms, ram, scratch areas, video and configurator are decoded by range.
// - control ram at 5C00-5FFF, socket window at 6000-6FFF.
// - the whole socket window stays addressable for every device type.
// - single-supply types get one pulse per byte; three-supply ones 100 passes.
// - blank means every bit reads one.
`timescale 1ns/100ps
`include "ebs_map.svh"
module eprom_burn_sequencer_decode
  import ebs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic burnKey,
  input wire logic copyInKey,
  input wire logic blockMode,
  input wire logic [15:0] blockSrc,
  input wire logic [15:0] blockLen,
  input wire logic [15:0] blockDst,
  input wire logic [2:0] devSelect,
  input wire logic [15:0] outboardLen,
  input wire logic cursorLoad,
  input wire logic [15:0] cursorValue,
  input wire logic cursorUp,
  input wire logic cursorDown,
  output logic [15:0] cursor,
  output logic [15:0] ramAddr,
  output logic ramWrite,
  output logic [7:0] ramWrData,
  input wire logic [7:0] ramRdData,
  output logic [15:0] sockAddr,
  output logic [7:0] sockWrData,
  output logic sockBurn,
  input wire logic burnDone,
  input wire logic [7:0] sockRdData,
  output logic sockPower,
  output logic busy,
  output logic resultPass,
  output logic resultFail,
  input wire logic addrLatch,
  input wire logic [7:0] dataBus,
  input wire logic [11:0] addrLow,
  output logic [3:0] addrHigh,
  output logic selRom,
  output logic selRam,
  output logic selScratchOne,
  output logic selVideo,
  output logic selConfig,
  output logic selControl,
  output logic selSocket,
  output logic selScratchTwo
);
  // 2k burn of 100 s: pulse slot per byte for a 2k part
  localparam longint RUN_CYCLES = longint'(`EBS_RUN_2K_S) * `EBS_CLK_HZ;
  localparam int SLOT_2K = int'(RUN_CYCLES / longint'(`EBS_LEN_2K));

  ebs_state_type state;
  ebs_state_type next_state;
  logic [15:0] index;
  logic [15:0] len;
  logic [15:0] srcBase;
  logic [15:0] dstBase;
  logic [6:0] pass;
  logic isBlock;
  logic isCopy;
  logic pulsing;
  logic doneSeen;
  logic [31:0] slotCount;

  wire keyStart = (burnKey || copyInKey) && (state == EBS_IDLE || state == EBS_DONE);
  wire threeRail = (devSelect == EBS_DEV_1K_3R) || (devSelect == EBS_DEV_2K_3R) ||
    (devSelect == EBS_DEV_512);
  wire [6:0] passTotal = threeRail ? `EBS_PASSES_3RAIL : 7'd1;
  wire [15:0] typeLen = (devSelect == EBS_DEV_512) ? `EBS_LEN_512 :
    (devSelect == EBS_DEV_1K_3R || devSelect == EBS_DEV_1K) ? `EBS_LEN_1K :
    (devSelect == EBS_DEV_2K_3R || devSelect == EBS_DEV_2K) ? `EBS_LEN_2K :
    (devSelect == EBS_DEV_OUTBOARD) ? outboardLen : `EBS_LEN_4K;
  wire [15:0] typeSrc = (devSelect == EBS_DEV_512 || devSelect == EBS_DEV_1K_3R) ?
    `EBS_SRC_512 : `EBS_SRC_STD;
  wire lastIndex = (index + 16'h0001) >= len;
  wire blankBad = sockRdData != `EBS_ERASED;
  wire verifyBad = sockRdData != ramRdData;
  wire slotOver = slotCount >= 32'(SLOT_2K - 1);
  // acknowledge is held until the slot has run out
  wire burnStep = pulsing && (burnDone || doneSeen) && slotOver;

  assign ramAddr = srcBase + index;
  assign sockAddr = dstBase + index;
  assign ramWrData = sockRdData;
  assign ramWrite = (state == EBS_COPY);
  assign sockWrData = ramRdData;
  assign busy = (state != EBS_IDLE) && (state != EBS_DONE);

  always_comb begin
    next_state = state;
    unique case (state)
      EBS_IDLE, EBS_DONE:
        if (keyStart) begin
          if (copyInKey) next_state = EBS_COPY;
          else if (blockMode) next_state = EBS_BURN;
          else next_state = EBS_BLANK;
        end
      EBS_BLANK:
        if (blankBad) next_state = EBS_DONE;
        else if (lastIndex) next_state = EBS_BURN;
      EBS_BURN:
        if (burnStep && lastIndex && (pass + 7'd1 >= passTotal)) next_state = EBS_VERIFY;
      EBS_VERIFY:
        if (verifyBad || lastIndex) next_state = EBS_DONE;
      EBS_COPY:
        if (lastIndex) next_state = EBS_VERIFY;
      default: next_state = EBS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state <= EBS_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index <= 16'h0000;
      len <= 16'h0000;
      srcBase <= 16'h0000;
      dstBase <= 16'h0000;
      pass <= 7'd0;
      isBlock <= 1'b0;
      isCopy <= 1'b0;
    end else if (keyStart) begin
      index <= 16'h0000;
      pass <= 7'd0;
      isCopy <= copyInKey;
      isBlock <= blockMode && !copyInKey;
      len <= (blockMode && !copyInKey) ? blockLen : typeLen;
      srcBase <= (blockMode && !copyInKey) ? blockSrc :
        (copyInKey ? `EBS_SRC_STD : typeSrc);
      dstBase <= (blockMode && !copyInKey) ? blockDst : `EBS_SOCK_LO;
    end else if (state != next_state) begin
      index <= 16'h0000;
    end else if (state == EBS_BURN) begin
      if (burnStep) begin
        index <= lastIndex ? 16'h0000 : index + 16'h0001;
        if (lastIndex) pass <= pass + 7'd1;
      end
    end else if (busy) begin
      index <= index + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulsing <= 1'b0;
      doneSeen <= 1'b0;
      slotCount <= 32'd0;
    end else if (state != EBS_BURN || burnStep) begin
      pulsing <= 1'b0;
      doneSeen <= 1'b0;
      slotCount <= 32'd0;
    end else begin
      pulsing <= 1'b1;
      if (pulsing && burnDone) doneSeen <= 1'b1;
      if (!slotOver) slotCount <= slotCount + 32'd1;
    end
  end
  assign sockBurn = (state == EBS_BURN) && !pulsing;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sockPower <= 1'b0;
      resultPass <= 1'b0;
      resultFail <= 1'b0;
    end else begin
      if (keyStart) begin
        sockPower <= 1'b1;
        resultPass <= 1'b0;
        resultFail <= 1'b0;
      end else if (state == EBS_BLANK && blankBad) begin
        resultFail <= 1'b1;
      end else if (state == EBS_VERIFY && verifyBad) begin
        resultFail <= 1'b1;
      end else if (state == EBS_VERIFY && lastIndex) begin
        resultPass <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cursor <= `EBS_RAM_LO;
    else if (cursorLoad) cursor <= cursorValue;
    else if (cursorUp) cursor <= {cursor[15:12], cursor[11:0] + 12'h001};
    else if (cursorDown) cursor <= {cursor[15:12], cursor[11:0] - 12'h001};
  end

  ebs_addr_decode u_decode (
    .clk(clk),
    .rst_b(rst_b),
    .addrLatch(addrLatch),
    .dataBus(dataBus),
    .addrLow(addrLow),
    .addrHigh(addrHigh),
    .fullAddr(),
    .selRom(selRom),
    .selRam(selRam),
    .selScratchOne(selScratchOne),
    .selVideo(selVideo),
    .selConfig(selConfig),
    .selControl(selControl),
    .selSocket(selSocket),
    .selScratchTwo(selScratchTwo)
  );
endmodule

// ---- src/ebs_map.svh ----
// ebs_map.svh: address map, device table and timing constants of the burn sequencer
// assumes a 16-bit control address bus and a 40 MHz clock
`ifndef EBS_MAP_SVH
`define EBS_MAP_SVH
`define EBS_CLK_HZ 40000000
`define EBS_ROM1_LO 16'h0000
`define EBS_ROM1_HI 16'h07FF
`define EBS_ROM2_LO 16'h1000
`define EBS_ROM2_HI 16'h17FF
`define EBS_ROM3_LO 16'h2000
`define EBS_ROM3_HI 16'h27FF
`define EBS_RAM_LO 16'h3000
`define EBS_RAM_HI 16'h3FFF
`define EBS_SCRATCH_AREA_ONE_LO 16'h4000
`define EBS_SCRATCH_AREA_ONE_HI 16'h4FFF
`define EBS_VID_LO 16'h5400
`define EBS_VID_HI 16'h57FF
`define EBS_CFG_LO 16'h5800
`define EBS_CFG_HI 16'h5BFF
`define EBS_CTL_LO 16'h5C00
`define EBS_CTL_HI 16'h5FFF
`define EBS_SOCK_LO 16'h6000
`define EBS_SOCK_HI 16'h6FFF
`define EBS_SCRATCH_AREA_TWO_LO 16'h7000
`define EBS_SCRATCH_AREA_TWO_HI 16'h73FF
`define EBS_SRC_512 16'h3400
`define EBS_SRC_STD 16'h3000
`define EBS_LEN_512 16'h0200
`define EBS_LEN_1K 16'h0400
`define EBS_LEN_2K 16'h0800
`define EBS_LEN_4K 16'h1000
`define EBS_ERASED 8'hFF
`define EBS_PASSES_3RAIL 7'd100
`define EBS_RUN_2K_S 100
`define EBS_PULSE_1RAIL_MS 50
`endif

// ---- src/ebs_pkg.sv ----
// ebs_pkg.sv: types of the burn sequencer
// assumes nothing beyond the map header
package ebs_pkg;
  typedef enum logic [2:0] {
    EBS_IDLE = 3'b000,
    EBS_BLANK = 3'b001,
    EBS_BURN = 3'b011,
    EBS_VERIFY = 3'b010,
    EBS_COPY = 3'b111,
    EBS_DONE = 3'b110
  } ebs_state_type;
  typedef enum logic [2:0] {
    EBS_DEV_512 = 3'd0,
    EBS_DEV_1K_3R = 3'd1,
    EBS_DEV_2K_3R = 3'd2,
    EBS_DEV_1K = 3'd3,
    EBS_DEV_2K = 3'd4,
    EBS_DEV_4K_A = 3'd5,
    EBS_DEV_4K_B = 3'd6,
    EBS_DEV_OUTBOARD = 3'd7
  } ebs_dev_type;
endpackage

// ---- src/ebs_addr_decode.sv ----
// ebs_addr_decode.sv: control processor address decoder and high-address latch
// assumes the high nibble appears on the data bus while addrLatch is high
`timescale 1ns/100ps
`include "ebs_map.svh"
module ebs_addr_decode
  import ebs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic addrLatch,
  input wire logic [7:0] dataBus,
  input wire logic [11:0] addrLow,
  output logic [3:0] addrHigh,
  output logic [15:0] fullAddr,
  output logic selRom,
  output logic selRam,
  output logic selScratchOne,
  output logic selVideo,
  output logic selConfig,
  output logic selControl,
  output logic selSocket,
  output logic selScratchTwo
);
  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addrHigh <= 4'h0;
    end else if (addrLatch) begin
      addrHigh <= dataBus[7:4];
    end
  end

  assign fullAddr = {addrHigh, addrLow};
  wire lowHalf = ~addrHigh[3];
  assign selRom = lowHalf && (inRange(fullAddr, `EBS_ROM1_LO, `EBS_ROM1_HI) ||
    inRange(fullAddr, `EBS_ROM2_LO, `EBS_ROM2_HI) ||
    inRange(fullAddr, `EBS_ROM3_LO, `EBS_ROM3_HI));
  assign selRam = lowHalf && inRange(fullAddr, `EBS_RAM_LO, `EBS_RAM_HI);
  assign selScratchOne = lowHalf && inRange(fullAddr, `EBS_SCRATCH_AREA_ONE_LO, `EBS_SCRATCH_AREA_ONE_HI);
  assign selVideo = lowHalf && inRange(fullAddr, `EBS_VID_LO, `EBS_VID_HI);
  assign selConfig = lowHalf && inRange(fullAddr, `EBS_CFG_LO, `EBS_CFG_HI);
  assign selControl = lowHalf && inRange(fullAddr, `EBS_CTL_LO, `EBS_CTL_HI);
  // whole window decoded whatever the device type
  assign selSocket = lowHalf && inRange(fullAddr, `EBS_SOCK_LO, `EBS_SOCK_HI);
  assign selScratchTwo = lowHalf && inRange(fullAddr, `EBS_SCRATCH_AREA_TWO_LO, `EBS_SCRATCH_AREA_TWO_HI);
endmodule

// ---- verif/ebs_seq_assertions.sv ----
// ebs_seq_assertions.sv: port checker for the burn sequencer
// assumes a bind onto the sequencer top; one clock, async low reset
`timescale 1ns/100ps
module ebs_seq_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic burnKey,
  input wire logic copyInKey,
  input wire logic busy,
  input wire logic resultPass,
  input wire logic resultFail,
  input wire logic sockPower,
  input wire logic sockBurn,
  input wire logic [7:0] sockWrData,
  input wire logic [7:0] ramRdData,
  input wire logic [15:0] sockAddr,
  input wire logic [15:0] ramAddr,
  input wire logic ramWrite,
  input wire logic [7:0] ramWrData,
  input wire logic [7:0] sockRdData,
  input wire logic addrLatch,
  input wire logic [7:0] dataBus,
  input wire logic [3:0] addrHigh,
  input wire logic [11:0] addrLow,
  input wire logic selRam,
  input wire logic selSocket
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  chk_power_start: assert property ($rose(sockPower) |->
    $past(burnKey) || $past(copyInKey))
    else $error("socket powered without a key");
  chk_power_hold: assert property (sockPower |=> sockPower)
    else $error("socket power dropped");
  chk_result_idle: assert property (resultPass || resultFail |-> !busy)
    else $error("result shown while busy");
  chk_copy_data: assert property (ramWrite |->
    ramWrData == sockRdData && sockAddr - ramAddr == 16'h3000)
    else $error("copy byte or address differs from socket");
  chk_burn_data: assert property (sockBurn |->
    sockWrData == ramRdData && sockAddr[15:12] == 4'h6)
    else $error("burn byte or address wrong");
  chk_high_latch: assert property (addrLatch |=> addrHigh == $past(dataBus[7:4]))
    else $error("high nibble not latched");
  chk_upper_free: assert property (addrHigh[3] |-> !selRam && !selSocket)
    else $error("upper half decoded");
  chk_ram_decode: assert property (selRam ==
    ({addrHigh, addrLow} inside {[16'h3000:16'h3fff]}))
    else $error("ram select wrong");
endmodule
bind eprom_burn_sequencer_decode ebs_seq_assertions ebs_seq_assertions_inst (.clk(clk),
  .rst_b(rst_b), .burnKey(burnKey), .copyInKey(copyInKey), .busy(busy), .resultPass(resultPass),
  .resultFail(resultFail), .sockPower(sockPower), .sockBurn(sockBurn), .sockWrData(sockWrData),
  .ramRdData(ramRdData), .sockAddr(sockAddr), .ramWrite(ramWrite), .ramWrData(ramWrData),
  .sockRdData(sockRdData), .addrLatch(addrLatch), .dataBus(dataBus), .addrHigh(addrHigh),
  .addrLow(addrLow), .selRam(selRam), .selSocket(selSocket), .ramAddr(ramAddr));

// ---- verif/ebs_eprom_model.sv ----
// ebs_eprom_model.sv: target part in the socket
// assumes the bench preloads mem; reads are combinational
`timescale 1ns/100ps
module ebs_eprom_model (
  input wire logic clk,
  input wire logic sockPower,
  input wire logic [15:0] sockAddr,
  input wire logic [7:0] sockWrData,
  input wire logic sockBurn,
  output logic burnDone,
  output logic [7:0] sockRdData
);
  logic [7:0] mem [0:4095];
  logic noise = 1'b0;
  always @(posedge clk) noise <= ~noise;
  // unpowered part shows a toggling pattern, not stale data
  assign sockRdData = sockPower ? mem[sockAddr[11:0]] : {8{noise}};
  // a pulse only clears bits, done one cycle later
  always @(posedge clk) begin
    burnDone <= sockBurn;
    if (sockBurn && sockPower) mem[sockAddr[11:0]] <= mem[sockAddr[11:0]] & sockWrData;
  end
endmodule

// ---- verif/tb_top.sv ----
// tb_top.sv: self-checking bench for the burn sequencer
// assumes the socket model and a 4k ram array in the bench
`timescale 1ns/100ps
module tb_top;
  import ebs_pkg::*;
  logic clk = 0, rst_b = 0, burnKey = 0, copyInKey = 0, cursorLoad = 0, cursorUp = 0;
  logic cursorDown = 0, addrLatch = 0, burnDone, sockBurn, sockPower, busy, ramWrite;
  logic resultPass, resultFail, prevRes = 0, burnSeen = 0;
  logic [7:0] sels;
  logic [2:0] devSelect = 0;
  logic [3:0] addrHigh;
  logic [7:0] dataBus = 0, ramRdData, ramWrData, sockWrData, sockRdData;
  logic [7:0] ram [0:4095];
  logic [11:0] addrLow = 0;
  logic [11:0] lows [8] = '{12'h000, 12'h3ff, 12'h400, 12'h7ff, 12'h800, 12'hbff, 12'hc00, 12'hfff};
  logic [15:0] cursorValue = 0, cursor, ramAddr, sockAddr;
  logic blockMode = 0;
  logic [15:0] blockSrc = 0, blockLen = 0, blockDst = 0, probe;
  logic expQ [$];
  int errCount = 0, checkCount = 0;
  eprom_burn_sequencer_decode eprom_burn_sequencer_decode_inst (.clk(clk), .rst_b(rst_b),
    .burnKey(burnKey), .copyInKey(copyInKey), .blockMode(blockMode), .blockSrc(blockSrc),
    .blockLen(blockLen), .blockDst(blockDst), .devSelect(devSelect), .outboardLen(16'h0000),
    .cursorLoad(cursorLoad), .cursorValue(cursorValue), .cursorUp(cursorUp),
    .cursorDown(cursorDown), .cursor(cursor), .ramAddr(ramAddr), .ramWrite(ramWrite),
    .ramWrData(ramWrData), .ramRdData(ramRdData), .sockAddr(sockAddr), .sockWrData(sockWrData),
    .sockBurn(sockBurn), .burnDone(burnDone), .sockRdData(sockRdData), .sockPower(sockPower),
    .busy(busy), .resultPass(resultPass), .resultFail(resultFail), .addrLatch(addrLatch),
    .dataBus(dataBus), .addrLow(addrLow), .addrHigh(addrHigh), .selRom(sels[0]),
    .selRam(sels[1]), .selScratchOne(sels[2]), .selVideo(sels[3]), .selConfig(sels[4]),
    .selControl(sels[5]), .selSocket(sels[6]), .selScratchTwo(sels[7]));
  ebs_eprom_model ebs_eprom_model_inst (.clk(clk), .sockPower(sockPower), .sockAddr(sockAddr),
    .sockWrData(sockWrData), .sockBurn(sockBurn), .burnDone(burnDone), .sockRdData(sockRdData));
  assign ramRdData = ram[ramAddr[11:0]];
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (ramWrite) ram[ramAddr[11:0]] <= ramWrData;
    if (sockBurn) burnSeen <= 1'b1;
    prevRes <= resultPass | resultFail;
    if (rst_b && (resultPass | resultFail) && !prevRes) begin
      if (expQ.size() == 0) cmp(16'h0000, 16'h0001, "extra result");
      else cmp(16'(resultPass), 16'(expQ.pop_front()), "result");
    end
  end
  function automatic logic [7:0] expSel(input logic [15:0] a);
    expSel = {a inside {[16'h7000:16'h73ff]}, a inside {[16'h6000:16'h6fff]},
      a inside {[16'h5c00:16'h5fff]}, a inside {[16'h5800:16'h5bff]},
      a inside {[16'h5400:16'h57ff]}, a inside {[16'h4000:16'h4fff]},
      a inside {[16'h3000:16'h3fff]},
      a inside {[16'h0000:16'h07ff], [16'h1000:16'h17ff], [16'h2000:16'h27ff]}};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic curs(input logic l, input logic u, input logic d, input logic [15:0] exp);
    {cursorLoad, cursorUp, cursorDown} = {l, u, d};
    step(1);
    cmp(cursor, exp, "cursor");
  endtask
  task automatic chkCopy(input int n);
    for (int i = 0; i < n; i++) begin
      cmp(16'(ram[i]), 16'(ebs_eprom_model_inst.mem[i]), "copy");
    end
  endtask
  task automatic runKey(input logic copy, input logic [2:0] dev);
    devSelect = dev;
    if (copy) copyInKey = 1;
    else burnKey = 1;
    step(1);
    {copyInKey, burnKey} = 2'b00;
    step(2);
    burnKey = 1;
    step(1);
    burnKey = 0;
    for (int n = 0; n < 20000 && busy !== 1'b0; n++) step(1);
    step(2);
  endtask
  task automatic endOfTest();
    if (expQ.size() != 0) errCount++;
    if (errCount == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    errCount++;
    endOfTest();
  end
  initial begin
    void'($urandom(32'ha212_e4ad));
    step(3);
    rst_b = 1;
    cmp(16'(sockPower), 16'h0000, "power");
    curs(0, 0, 1, 16'h3fff);
    curs(0, 1, 0, 16'h3000);
    cursorValue = 16'h2fff;
    curs(1, 0, 0, 16'h2fff);
    curs(0, 1, 0, 16'h2000);
    {cursorLoad, cursorUp, cursorDown} = 3'b000;
    for (int h = 0; h < 16; h++) begin
      {addrLatch, dataBus} = {1'b1, h[3:0], 4'($urandom)};
      step(1);
      {addrLatch, dataBus} = {1'b0, 8'($urandom)};
      for (int k = 0; k < 8; k++) begin
        addrLow = lows[k];
        probe = {h[3:0], lows[k]};
        step(1);
        cmp(16'(addrHigh), 16'(h[3:0]), "high");
        cmp(16'(sels), 16'(expSel(probe)), "dec");
      end
    end
    for (int i = 0; i < 4096; i++) ebs_eprom_model_inst.mem[i] = 8'($urandom);
    expQ.push_back(1'b1);
    runKey(1, 3'd3);
    chkCopy(1024);
    for (int i = 0; i < 4096; i++) ebs_eprom_model_inst.mem[i] = 8'hff;
    ebs_eprom_model_inst.mem[9] = 8'hfe;
    expQ.push_back(1'b0);
    runKey(0, 3'd4);
    cmp(16'(burnSeen), 16'h0000, "burn");
    cmp(16'(sockPower), 16'h0001, "power");
    for (int i = 0; i < 4096; i++) ebs_eprom_model_inst.mem[i] = 8'h00;
    blockMode = 1;
    blockSrc = {6'b001100, 10'($urandom)};
    blockLen = 16'($urandom_range(64, 1));
    blockDst = 16'h6321;
    burnKey = 1;
    step(1);
    burnKey = 0;
    cmp(16'(sockBurn), 16'h0001, "block burn");
    cmp(sockAddr, 16'h6321, "block target");
    cmp(16'(sockWrData), 16'(ram[blockSrc[11:0]]), "block data");
    step(3);
    cmp(16'(sockBurn), 16'h0000, "one pulse");
    cmp(16'(busy), 16'h0001, "busy");
    rst_b = 0;
    step(1);
    cmp(16'(sockPower), 16'h0000, "power");
    cmp(16'(busy), 16'h0000, "reset idle");
    rst_b = 1;
    blockMode = 0;
    for (int i = 0; i < 4096; i++) ebs_eprom_model_inst.mem[i] = 8'($urandom);
    expQ.push_back(1'b1);
    runKey(1, 3'd0);
    chkCopy(512);
    rst_b = 0;
    step(1);
    cmp(16'(sockPower), 16'h0000, "power");
    endOfTest();
  end
endmodule
